/* File: verilog/irs_sequencer.sv */
// Instruction read-out sequencer: storage cycles, address update and character ring.
// Assumes storage presents the read character on b_channel by clock point D.
`timescale 1ns/10ps
module irs_sequencer
	import irs_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic start_key,
	input wire logic program_reset,
	input wire logic last_execute_cycle,
	input wire logic manual_operation,
	input wire logic run_mode,
	input wire logic single_step,
	input wire logic fast_storage,
	input wire logic io_class_opcodes,
	input wire logic index_hold,
	input wire logic [7:0] b_channel,
	output logic [19:0] storage_address_reg,
	output logic [19:0] instruction_address_reg,
	output logic storage_read,
	output logic storage_regen,
	output logic stop_at_point_f,
	output logic addr_mod_plus_one,
	output logic [12:0] ring,
	output logic [7:0] a_register,
	output logic op_load,
	output logic [4:0] addr_digit_load,
	output logic addr_second,
	output logic [3:0] addr_digit,
	output logic io_unit_load,
	output logic [3:0] index_tag,
	output logic instruction_check,
	output logic address_check,
	output logic validity_check,
	output logic cpu_stop,
	output logic stop_latch,
	output logic branch_forcing,
	output logic process_routine,
	output logic final_readout_cycle,
	output logic i_phase_done
);

	irs_state_t state;
	irs_state_t next_state;
	logic start_q1, start_q2, start_q3;
	logic reset_q1, reset_q2;
	logic start_edge;
	logic point_a, point_b, point_d, point_e, point_f;
	logic [19:0] incr_addr;
	logic [19:0] mod_addr;
	logic [19:0] next_mod_addr;
	logic last_flag;
	logic next_last_flag;
	logic [7:0] asm_char;
	logic chars_ok;
	logic [3:0] stage;
	logic [2:0] pos;
	logic [19:0] next_storage_address_reg;
	logic [19:0] next_instruction_address_reg;
	logic next_storage_read;
	logic next_storage_regen;
	logic next_stop_at_point_f;
	logic next_addr_mod_plus_one;
	logic [12:0] next_ring;
	logic [7:0] next_a_register;
	logic next_op_load;
	logic [4:0] next_addr_digit_load;
	logic next_addr_second;
	logic [3:0] next_addr_digit;
	logic next_io_unit_load;
	logic [3:0] next_index_tag;
	logic next_instruction_check;
	logic next_address_check;
	logic next_validity_check;
	logic next_cpu_stop;
	logic next_stop_latch;
	logic next_branch_forcing;
	logic next_process_routine;
	logic next_final_readout_cycle;
	logic next_i_phase_done;

	irs_point_timer u_timer (
		.clock(clock),
		.reset(reset),
		.run(state == IRS_READ),
		.fast(fast_storage),
		.point_a(point_a),
		.point_b(point_b),
		.point_d(point_d),
		.point_e(point_e),
		.point_f(point_f)
	);

	irs_bcd_incr u_incr (
		.addr(storage_address_reg),
		.sum(incr_addr)
	);

	// Stage number of the one-hot ring
	always_comb begin
		stage = 4'h0;
		for (int k = 0; k < IRS_RING_W; k++) begin
			if (ring[k]) begin
				stage = 4'(k);
			end
		end
	end

	always_comb begin
		start_edge = start_q2 && !start_q3;
		// Assembly takes numerics, zones and word mark from the A channel
		asm_char = {a_register[IRS_MARK_BIT], ~^a_register[5:0], a_register[5:0]};
		chars_ok = irs_parity_ok(a_register) && irs_parity_ok(asm_char)
			&& (a_register[3:0] <= IRS_DIGIT_MAX);
		pos = (stage > 4'(IRS_UNITS_STAGE)) ? 3'(stage - 4'(IRS_UNITS_STAGE)) : 3'(stage);
	end

	always_comb begin
		next_state = state;
		next_mod_addr = mod_addr;
		next_last_flag = last_flag;
		next_storage_address_reg = storage_address_reg;
		next_instruction_address_reg = instruction_address_reg;
		next_storage_read = 1'b0;
		next_storage_regen = storage_regen;
		next_stop_at_point_f = (state == IRS_READ);
		next_addr_mod_plus_one = (state == IRS_READ);
		next_ring = ring;
		next_a_register = a_register;
		next_op_load = 1'b0;
		next_addr_digit_load = 5'h00;
		next_addr_second = addr_second;
		next_addr_digit = addr_digit;
		next_io_unit_load = 1'b0;
		next_index_tag = index_tag;
		next_instruction_check = instruction_check;
		next_address_check = address_check;
		next_validity_check = validity_check;
		next_cpu_stop = cpu_stop;
		next_stop_latch = stop_latch;
		next_branch_forcing = branch_forcing;
		next_process_routine = process_routine;
		next_final_readout_cycle = 1'b0;
		next_i_phase_done = 1'b0;
		if (manual_operation) begin
			next_process_routine = 1'b0;
		end
		case (state)
			IRS_IDLE: begin
				if (stop_latch && branch_forcing && start_edge) begin
					next_stop_latch = 1'b0;
					next_process_routine = 1'b1;
					next_state = IRS_READ;
					next_ring = IRS_RING_OP;
				end else if (start_edge && !process_routine && (run_mode || single_step)) begin
					next_process_routine = 1'b1;
					next_state = IRS_READ;
					next_ring = IRS_RING_OP;
				end else if (last_execute_cycle && !stop_latch) begin
					next_state = IRS_READ;
					next_ring = IRS_RING_OP;
				end
			end
			IRS_READ: begin
				if (point_a) begin
					// Forced start address blocks the instruction address path
					next_storage_address_reg = branch_forcing ? IRS_START_ADDR : instruction_address_reg;
					next_branch_forcing = 1'b0;
					next_storage_read = 1'b1;
					next_last_flag = 1'b0;
				end
				if (point_b) begin
					next_mod_addr = incr_addr;
				end
				if (point_d) begin
					next_a_register = b_channel;
					next_storage_regen = 1'b1;
				end
				if (point_e) begin
					if (ring[0]) begin
						if (!a_register[IRS_MARK_BIT]) begin
							next_instruction_check = 1'b1;
							next_cpu_stop = 1'b1;
							next_state = IRS_HALT;
						end else begin
							next_op_load = 1'b1;
						end
					end else if (a_register[IRS_MARK_BIT]) begin
						next_last_flag = 1'b1;
						next_final_readout_cycle = 1'b1;
					end else if (!chars_ok) begin
						next_validity_check = 1'b1;
						next_cpu_stop = 1'b1;
						next_state = IRS_HALT;
					end else if (stage <= 4'(2 * IRS_UNITS_STAGE)) begin
						if ((pos == 3'd3) || (pos == 3'd4)) begin
							next_index_tag[2*(pos - 3'd3) +: 2] = a_register[5:4];
						end else if (a_register[5:4] != 2'b00) begin
							next_address_check = 1'b1;
							next_cpu_stop = 1'b1;
							next_state = IRS_HALT;
						end
						if (pos == 3'd1) begin
							next_index_tag = 4'h0;
						end
						next_addr_digit = a_register[3:0];
						next_addr_second = (stage > 4'(IRS_UNITS_STAGE));
						if ((stage == 4'(IRS_UNITS_STAGE)) && io_class_opcodes) begin
							next_io_unit_load = 1'b1;
						end else begin
							next_addr_digit_load = 5'h01 << (3'd5 - pos);
						end
					end
				end
				if (point_f && (next_state == IRS_READ)) begin
					next_storage_regen = 1'b0;
					if (last_flag) begin
						// Word-marked character is the next op code; reread it
						next_instruction_address_reg = storage_address_reg;
						next_ring = IRS_RING_OFF;
						next_i_phase_done = 1'b1;
						next_state = IRS_IDLE;
					end else begin
						next_instruction_address_reg = mod_addr;
						if (!index_hold && !ring[IRS_LAST_STAGE]) begin
							next_ring = {ring[IRS_RING_W-2:0], 1'b0};
						end
					end
				end
			end
			IRS_HALT: begin
				next_storage_regen = 1'b0;
				next_ring = IRS_RING_OFF;
			end
			default: begin
				next_state = IRS_IDLE;
			end
		endcase
		if (reset_q2) begin
			next_state = IRS_IDLE;
			next_stop_latch = 1'b1;
			next_branch_forcing = 1'b1;
			next_process_routine = 1'b0;
			next_instruction_check = 1'b0;
			next_address_check = 1'b0;
			next_validity_check = 1'b0;
			next_cpu_stop = 1'b0;
			next_ring = IRS_RING_OFF;
			next_storage_regen = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= IRS_IDLE;
			start_q1 <= 1'b0;
			start_q2 <= 1'b0;
			start_q3 <= 1'b0;
			reset_q1 <= 1'b0;
			reset_q2 <= 1'b0;
			mod_addr <= IRS_ADDR_RESET;
			last_flag <= 1'b0;
			storage_address_reg <= IRS_ADDR_RESET;
			instruction_address_reg <= IRS_ADDR_RESET;
			storage_read <= 1'b0;
			storage_regen <= 1'b0;
			stop_at_point_f <= 1'b0;
			addr_mod_plus_one <= 1'b0;
			ring <= IRS_RING_OFF;
			a_register <= IRS_CHAR_RESET;
			op_load <= 1'b0;
			addr_digit_load <= 5'h00;
			addr_second <= 1'b0;
			addr_digit <= 4'h0;
			io_unit_load <= 1'b0;
			index_tag <= 4'h0;
			instruction_check <= 1'b0;
			address_check <= 1'b0;
			validity_check <= 1'b0;
			cpu_stop <= 1'b0;
			stop_latch <= 1'b1;
			branch_forcing <= 1'b1;
			process_routine <= 1'b0;
			final_readout_cycle <= 1'b0;
			i_phase_done <= 1'b0;
		end else begin
			state <= next_state;
			start_q1 <= start_key;
			start_q2 <= start_q1;
			start_q3 <= start_q2;
			reset_q1 <= program_reset;
			reset_q2 <= reset_q1;
			mod_addr <= next_mod_addr;
			last_flag <= next_last_flag;
			storage_address_reg <= next_storage_address_reg;
			instruction_address_reg <= next_instruction_address_reg;
			storage_read <= next_storage_read;
			storage_regen <= next_storage_regen;
			stop_at_point_f <= next_stop_at_point_f;
			addr_mod_plus_one <= next_addr_mod_plus_one;
			ring <= next_ring;
			a_register <= next_a_register;
			op_load <= next_op_load;
			addr_digit_load <= next_addr_digit_load;
			addr_second <= next_addr_second;
			addr_digit <= next_addr_digit;
			io_unit_load <= next_io_unit_load;
			index_tag <= next_index_tag;
			instruction_check <= next_instruction_check;
			address_check <= next_address_check;
			validity_check <= next_validity_check;
			cpu_stop <= next_cpu_stop;
			stop_latch <= next_stop_latch;
			branch_forcing <= next_branch_forcing;
			process_routine <= next_process_routine;
			final_readout_cycle <= next_final_readout_cycle;
			i_phase_done <= next_i_phase_done;
		end
	end

endmodule

/* File: verilog/irs_pkg.sv */
// Constants, types and shared decoding for the instruction read-out sequencer.
// Assumes a single 40 MHz clock for everything that includes it.
package irs_pkg;

	localparam int IRS_CLOCK_NS = 25;
	localparam int IRS_CYCLE_NS = 4500;
	localparam int IRS_FAST_CYCLE_NS = 4000;
	localparam int IRS_CYCLE_CLKS = IRS_CYCLE_NS / IRS_CLOCK_NS;
	localparam int IRS_FAST_CYCLE_CLKS = IRS_FAST_CYCLE_NS / IRS_CLOCK_NS;
	localparam int IRS_PT_B_NS = 750;
	localparam int IRS_PT_D_NS = 2250;
	localparam int IRS_PT_E_NS = 3000;
	localparam int IRS_PT_B_CLKS = (IRS_PT_B_NS + IRS_CLOCK_NS - 1) / IRS_CLOCK_NS;
	localparam int IRS_PT_D_CLKS = (IRS_PT_D_NS + IRS_CLOCK_NS - 1) / IRS_CLOCK_NS;
	localparam int IRS_PT_E_CLKS = (IRS_PT_E_NS + IRS_CLOCK_NS - 1) / IRS_CLOCK_NS;
	localparam int IRS_CNT_W = 8;

	localparam logic [19:0] IRS_START_ADDR = 20'h0_0001;
	localparam logic [19:0] IRS_ADDR_RESET = 20'h0_0000;

	localparam int IRS_RING_W = 13;
	localparam int IRS_UNITS_STAGE = 5;
	localparam int IRS_LAST_STAGE = 12;
	localparam logic [12:0] IRS_RING_OFF = 13'h0000;
	localparam logic [12:0] IRS_RING_OP = 13'h0001;

	localparam int IRS_MARK_BIT = 7;
	localparam int IRS_C_BIT = 6;
	localparam logic [7:0] IRS_CHAR_RESET = 8'h00;
	localparam logic [3:0] IRS_DIGIT_MAX = 4'hA;

	typedef enum logic [1:0] {
		IRS_IDLE = 2'b00,
		IRS_READ = 2'b01,
		IRS_HALT = 2'b11
	} irs_state_t;

	// Odd parity over check, zone and numeric bits
	function automatic logic irs_parity_ok(input logic [7:0] ch);
		irs_parity_ok = ^ch[IRS_C_BIT:0];
	endfunction

endpackage

/* File: verilog/irs_point_timer.sv */
// Storage cycle timer producing clock point pulses A, B, D, E and F.
// Assumes run stays high for the whole read-out phase.
`timescale 1ns/10ps
module irs_point_timer
	import irs_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic run,
	input wire logic fast,
	output logic point_a,
	output logic point_b,
	output logic point_d,
	output logic point_e,
	output logic point_f
);

	logic [IRS_CNT_W-1:0] count;
	logic [IRS_CNT_W-1:0] next_count;
	logic [IRS_CNT_W-1:0] last;

	always_comb begin
		last = fast ? IRS_CNT_W'(IRS_FAST_CYCLE_CLKS - 1) : IRS_CNT_W'(IRS_CYCLE_CLKS - 1);
		point_a = run && (count == '0);
		point_b = run && (count == IRS_CNT_W'(IRS_PT_B_CLKS));
		point_d = run && (count == IRS_CNT_W'(IRS_PT_D_CLKS));
		point_e = run && (count == IRS_CNT_W'(IRS_PT_E_CLKS));
		point_f = run && (count == last);
		if (!run || point_f) begin
			next_count = '0;
		end else begin
			next_count = count + IRS_CNT_W'(1);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

endmodule

/* File: verilog/irs_bcd_incr.sv */
// Five-digit decimal plus-one modifier for storage addresses.
// Assumes digits are plain BCD, 0 to 9.
`timescale 1ns/10ps
module irs_bcd_incr
	import irs_pkg::*;
(
	input wire logic [19:0] addr,
	output logic [19:0] sum
);

	logic [5:0] carry;

	assign carry[0] = 1'b1;

	genvar i;
	generate
		for (i = 0; i < 5; i++) begin : g_digit
			always_comb begin
				if (carry[i] && (addr[4*i +: 4] == 4'h9)) begin
					sum[4*i +: 4] = 4'h0;
					carry[i+1] = 1'b1;
				end else begin
					sum[4*i +: 4] = addr[4*i +: 4] + {3'h0, carry[i]};
					carry[i+1] = 1'b0;
				end
			end
		end
	endgenerate

endmodule

/* File: verification/irs_sequencer_props.sv */
// Checker on the ports of the read-out sequencer.
// Assumes one clock and an async active-high reset.
`timescale 1ns/10ps
module irs_sequencer_props
	import irs_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic fast_storage,
	input wire logic io_class_opcodes,
	input wire logic index_hold,
	input wire logic validity_check,
	input wire logic storage_read,
	input wire logic storage_regen,
	input wire logic stop_at_point_f,
	input wire logic addr_mod_plus_one,
	input wire logic [19:0] storage_address_reg,
	input wire logic [19:0] instruction_address_reg,
	input wire logic [12:0] ring,
	input wire logic [4:0] addr_digit_load,
	input wire logic addr_second,
	input wire logic io_unit_load,
	input wire logic address_check,
	input wire logic instruction_check,
	input wire logic cpu_stop,
	input wire logic branch_forcing,
	input wire logic i_phase_done
);
	logic [7:0] cnt;
	logic live;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Clocks since the last storage cycle began
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cnt <= 8'h00;
			live <= 1'b0;
		end else begin
			cnt <= storage_read ? 8'h01 : cnt + 8'h01;
			live <= storage_read | (live & ~i_phase_done & ~cpu_stop);
		end
	end
	sequence regen_seq;
		##[1:120] storage_regen ##[1:120] !storage_regen;
	endsequence
	ring_onehot_a: assert property (ring != IRS_RING_OFF |-> $onehot(ring))
		else $error("ring not one-hot");
	ring_step_a: assert property ((ring != 0 && $past(ring) != 0 && ring != $past(ring))
		|-> ring == ($past(ring) << 1)) else $error("ring skipped a stage");
	cycle_len_a: assert property (storage_read && live |-> cnt == (fast_storage ? 8'd160 : 8'd180))
		else $error("storage cycle length wrong");
	read_mode_a: assert property (storage_read |-> stop_at_point_f && addr_mod_plus_one)
		else $error("read without plus one or stop at F");
	start_addr_a: assert property (storage_read && $past(branch_forcing) |-> storage_address_reg == IRS_START_ADDR)
		else $error("forced start address missing");
	iar_copy_a: assert property (storage_read && !$past(branch_forcing) |-> storage_address_reg == instruction_address_reg)
		else $error("address not taken from instruction address");
	regen_cycle_a: assert property (storage_read |-> regen_seq)
		else $error("character not written back");
	units_load_a: assert property (addr_digit_load[0] && !addr_second |-> ring[5] && !io_class_opcodes)
		else $error("units load outside stage five");
	io_load_a: assert property (io_unit_load |-> ring[5] && io_class_opcodes && addr_digit_load == 5'h00)
		else $error("unit register load wrong");
	check_stop_a: assert property ($rose(address_check) || $rose(instruction_check) || $rose(validity_check) |-> ##[0:2] cpu_stop)
		else $error("check did not stop");
	ring_hold_a: assert property ($past(index_hold) && $past(ring) != 0 && ring != 0 |-> ring == $past(ring))
		else $error("ring moved while held");
endmodule

/* File: verification/irs_store.sv */
// Character store answering each storage cycle on b_channel.
// Assumes storage_read starts a cycle and storage_regen ends it.
`timescale 1ns/10ps
module irs_store
	import irs_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic storage_read,
	input wire logic storage_regen,
	input wire logic [19:0] storage_address_reg,
	input wire logic [7:0] a_register,
	output logic [7:0] b_channel
);
	logic [7:0] mem [0:255];
	logic hold;
	logic rg;
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			b_channel <= 8'h00;
			hold <= 1'b0;
			rg <= 1'b0;
		end else begin
			rg <= storage_regen;
			if (storage_read) begin
				b_channel <= mem[storage_address_reg[7:0]];
				hold <= 1'b1;
			end else if (rg && !storage_regen) begin
				mem[storage_address_reg[7:0]] <= a_register;
				hold <= 1'b0;
			end else if (!hold) begin
				b_channel <= ~b_channel;
			end
		end
	end
endmodule

/* File: verification/irs_sequencer_tb.sv */
// Testbench: instruction read-outs from a character store.
// Assumes the store model drives b_channel.
`timescale 1ns/10ps
module irs_sequencer_tb
	import irs_pkg::*;
;
	logic clock = 0, reset = 1, start_key = 0, program_reset = 0, last_execute_cycle = 0;
	logic manual_operation = 0, run_mode = 0, single_step = 0, fast_storage = 0, io_class_opcodes = 0;
	logic index_hold = 0, storage_read, storage_regen, stop_at_point_f, addr_mod_plus_one, op_load;
	logic addr_second, io_unit_load, instruction_check, address_check, validity_check, cpu_stop;
	logic stop_latch, branch_forcing, process_routine, final_readout_cycle, i_phase_done;
	logic [19:0] storage_address_reg, instruction_address_reg;
	logic [12:0] ring;
	logic [7:0] a_register, b_channel;
	logic [4:0] addr_digit_load;
	logic [3:0] addr_digit, index_tag, tag_seen, digit_seen;
	int fail_count = 0, n_checks = 0, units_n = 0, io_n = 0, op_n = 0, fin_n = 0;
	initial forever #12.5 clock = ~clock;
	irs_sequencer i_irs_sequencer (.clock, .reset, .start_key, .program_reset, .last_execute_cycle,
		.manual_operation, .run_mode, .single_step, .fast_storage, .io_class_opcodes, .index_hold,
		.b_channel, .storage_address_reg, .instruction_address_reg, .storage_read, .storage_regen,
		.stop_at_point_f, .addr_mod_plus_one, .ring, .a_register, .op_load, .addr_digit_load,
		.addr_second, .addr_digit, .io_unit_load, .index_tag, .instruction_check, .address_check,
		.validity_check, .cpu_stop, .stop_latch, .branch_forcing, .process_routine,
		.final_readout_cycle, .i_phase_done);
	irs_store i_irs_store (.clock, .reset, .storage_read, .storage_regen, .storage_address_reg,
		.a_register, .b_channel);
	always @(negedge clock) begin
		if (addr_digit_load[0] === 1'b1 && addr_second === 1'b0) begin
			units_n++;
			tag_seen = index_tag;
			digit_seen = addr_digit;
		end
		if (io_unit_load === 1'b1) begin
			io_n++;
			tag_seen = index_tag;
		end
		if (op_load === 1'b1) op_n++;
		if (final_readout_cycle === 1'b1) fin_n++;
	end
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task check(input logic [19:0] got, input logic [19:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task press;
		start_key = 1;
		tick(4);
		start_key = 0;
		tick(2);
	endtask
	task wait_for(input int sel);
		int i;
		for (i = 0; i < 4000; i++) begin
			tick(1);
			if ((sel == 2) ? (op_n >= 2) : (((sel == 1) ? cpu_stop : i_phase_done) === 1'b1)) break;
		end
		if (i == 4000) begin
			fail_count++;
			$display("Error %0t: wait ran out", $time);
			summarize();
		end
	endtask
	function automatic logic [7:0] mk(input logic w, input logic [1:0] z, input logic [3:0] n);
		mk = {w, ~^{z, n}, z, n};
	endfunction
	initial begin
		tick(3);
		reset = 0;
		tick(2);
		check(stop_latch, 1);
		check(branch_forcing, 1);
		i_irs_store.mem[8'h01] = mk(1, 0, 4);
		for (int k = 1; k < 6; k++) i_irs_store.mem[8'h01 + k] = mk(0, 0, k);
		i_irs_store.mem[8'h07] = mk(1, 0, 7);
		i_irs_store.mem[8'h08] = mk(0, 0, 1);
		i_irs_store.mem[8'h09] = mk(0, 0, 2);
		i_irs_store.mem[8'h10] = mk(0, 2'b10, 3);
		i_irs_store.mem[8'h11] = mk(0, 0, 4);
		i_irs_store.mem[8'h12] = mk(0, 0, 5);
		i_irs_store.mem[8'h13] = mk(1, 0, 3);
		for (int k = 4; k < 8; k++) i_irs_store.mem[8'h10 + k] = mk(0, 0, k);
		i_irs_store.mem[8'h18] = mk(0, 2'b01, 9);
		press;
		wait_for(0);
		check(instruction_address_reg, 20'h0_0007);
		check(units_n, 1);
		check(digit_seen, 5);
		check(stop_latch, 0);
		fast_storage = 1;
		io_class_opcodes = 1;
		last_execute_cycle = 1;
		tick(1);
		last_execute_cycle = 0;
		wait_for(0);
		check(instruction_address_reg, 20'h0_0013);
		check(io_n, 1);
		check(units_n, 1);
		check(tag_seen, 4'b0010);
		check(fin_n, 2);
		fast_storage = 0;
		io_class_opcodes = 0;
		manual_operation = 1;
		tick(2);
		check(process_routine, 0);
		manual_operation = 0;
		single_step = 1;
		press;
		check(process_routine, 1);
		wait_for(1);
		check(address_check, 1);
		check(instruction_check, 0);
		check(op_n, 3);
		program_reset = 1;
		tick(4);
		program_reset = 0;
		tick(2);
		check(address_check, 0);
		check(branch_forcing, 1);
		i_irs_store.mem[8'h01] = mk(0, 0, 4);
		press;
		wait_for(1);
		check(instruction_check, 1);
		check(storage_address_reg, 20'h0_0001);
		program_reset = 1;
		tick(4);
		program_reset = 0;
		tick(2);
		op_n = 0;
		index_hold = 1;
		i_irs_store.mem[8'h01] = mk(1, 0, 4);
		i_irs_store.mem[8'h02] = mk(1, 0, 6);
		i_irs_store.mem[8'h03] = mk(0, 0, 1) ^ 8'h40;
		press;
		wait_for(2);
		index_hold = 0;
		wait_for(1);
		check(op_n, 2);
		check(instruction_address_reg, 20'h0_0003);
		check(validity_check, 1);
		check(instruction_check, 0);
		summarize();
	end
endmodule
bind irs_sequencer irs_sequencer_props i_irs_sequencer_props (.clock, .reset, .fast_storage, .io_class_opcodes,
	.storage_read, .storage_regen, .stop_at_point_f, .addr_mod_plus_one, .storage_address_reg,
	.instruction_address_reg, .ring, .addr_digit_load, .addr_second, .io_unit_load, .address_check,
	.instruction_check, .cpu_stop, .branch_forcing, .i_phase_done, .index_hold, .validity_check);
